/* File: verilog/hsl_consts.svh */
`ifndef HSL_CONSTS_SVH
`define HSL_CONSTS_SVH

// apb register map, byte addresses
`define HSL_ADDR_W              12
`define HSL_CTRL_OFFSET         12'h000
`define HSL_STATUS_OFFSET       12'h004

// control register fields and reset value
`define HSL_CTRL_SPEED_LED_BIT  0
`define HSL_CTRL_SUSP_LED_BIT   1
`define HSL_CTRL_W              2
`define HSL_CTRL_RESET          2'h3

// status register fields
`define HSL_ST_VALID_BIT        0
`define HSL_ST_CODE_LSB         1
`define HSL_ST_MASK_LSB         3
`define HSL_ST_COMPOUND_BIT     7
`define HSL_ST_METHOD_LSB       8
`define HSL_ST_ALLOW_BIT        10
`define HSL_ST_SPEED_BIT        11
`define HSL_ST_SUSP_BIT         12

// downstream ports present (bit n-1 = port n)
`define HSL_PORT_EXISTS         4'hF

// fixed-port masks per strap code
`define HSL_MASK_CODE0          4'h0
`define HSL_MASK_CODE1          4'h1
`define HSL_MASK_CODE2          4'h3
`define HSL_MASK_CODE3          4'h7

// least reset pulse from the system, and its length in pclk cycles
`define HSL_PCLK_HZ             10000000
`define HSL_RESET_MIN_NS        1000
`define HSL_RESET_MIN_CYC       ((`HSL_RESET_MIN_NS * (`HSL_PCLK_HZ / 1000000) + 999) / 1000)

`endif

/* File: verilog/hsl_pkg.sv */
`default_nettype none

package hsl_pkg;

    // one bit per strap pin, as caught at reset release
    typedef struct packed {
        logic select_b;
        logic select_a;
        logic fixed_hi;
        logic fixed_lo;
    } hsl_straps_s;

    typedef enum logic {
        HSL_WAIT_CAPTURE,
        HSL_RUN
    } hsl_state_e;

endpackage

`default_nettype wire

/* File: verilog/hsl_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// two-flop synchroniser, no reset so it follows the pin while reset is low
module hsl_pin_sync (
    // clock
    input  wire logic pclk,
    // pin side
    input  wire logic pin_in,
    // core side
    output var  logic pin_sync
);

    logic meta_q;
    logic sync_q;

    always_ff @(posedge pclk) begin
        meta_q <= pin_in;
        sync_q <= meta_q;
    end

    assign pin_sync = sync_q;

endmodule // hsl_pin_sync

`default_nettype wire

/* File: verilog/hsl_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hsl_consts.svh"

// Overview of operation
// - sample both fixed-port straps together at release
// - decode code into fixed downstream port mask
// - any fixed port means compound device
// - latch select A at reset release
// - latch select B, combine into method
// - speed indicator on for high speed only
// - LED polarity follows sampled strap value
module hsl_top (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // apb slave
    input  wire logic [`HSL_ADDR_W-1:0]   paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output var  logic [31:0]              prdata,
    output var  logic                     pready,
    output var  logic                     pslverr,
    // strap pins
    input  wire logic                     fixed_port_strap_hi_in,
    input  wire logic                     fixed_port_strap_lo_in,
    input  wire logic                     config_method_select_a_in,
    input  wire logic                     config_method_select_b_in,
    // shared indicator pin drivers
    output var  logic                     suspend_indicator_out,
    output var  logic                     suspend_indicator_oe,
    output var  logic                     upstream_speed_indicator_out,
    output var  logic                     upstream_speed_indicator_oe,
    // hub core status, same clock
    input  wire logic                     strap_allow,
    input  wire logic                     hub_connected,
    input  wire logic                     hub_high_speed,
    input  wire logic                     hub_active,
    // decoded configuration
    output var  hsl_pkg::hsl_straps_s     captured_straps,
    output var  logic [1:0]               fixed_port_code,
    output var  logic [3:0]               fixed_port_mask,
    output var  logic                     compound_device,
    output var  logic [1:0]               config_method,
    output var  logic                     straps_valid
);

    function automatic logic [3:0] fixed_mask(input logic [1:0] code);
        logic [3:0] m;
        m = `HSL_MASK_CODE0;
        case (code)
            2'h1:    m = `HSL_MASK_CODE1;
            2'h2:    m = `HSL_MASK_CODE2;
            2'h3:    m = `HSL_MASK_CODE3;
            default: m = `HSL_MASK_CODE0;
        endcase
        return m & `HSL_PORT_EXISTS;
    endfunction

    // pin synchronisers
    logic [3:0]             pin_raw;
    logic [3:0]             pin_sync;
    hsl_pkg::hsl_straps_s   straps_now;

    assign pin_raw = {config_method_select_b_in, config_method_select_a_in,
                      fixed_port_strap_hi_in, fixed_port_strap_lo_in};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            hsl_pin_sync u_sync (
                .pclk     (pclk),
                .pin_in   (pin_raw[gi]),
                .pin_sync (pin_sync[gi])
            );
        end
    endgenerate

    assign straps_now = hsl_pkg::hsl_straps_s'(pin_sync);

    // capture at release
    hsl_pkg::hsl_state_e    state_q;
    hsl_pkg::hsl_state_e    state_d;
    hsl_pkg::hsl_straps_s   straps_q;
    hsl_pkg::hsl_straps_s   straps_d;
    logic                   allow_q;
    logic                   allow_d;
    logic                   capture;

    always_comb begin
        state_d = state_q;
        case (state_q)
            hsl_pkg::HSL_WAIT_CAPTURE: state_d = hsl_pkg::HSL_RUN;
            hsl_pkg::HSL_RUN:          state_d = hsl_pkg::HSL_RUN;
            default:                   state_d = hsl_pkg::HSL_WAIT_CAPTURE;
        endcase
    end

    assign capture  = (state_q == hsl_pkg::HSL_WAIT_CAPTURE);
    assign straps_d = capture ? straps_now : straps_q;
    assign allow_d  = capture ? strap_allow : allow_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= hsl_pkg::HSL_WAIT_CAPTURE;
            straps_q <= '0;
            allow_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            straps_q <= straps_d;
            allow_q  <= allow_d;
        end
    end

    // decode
    logic [1:0] code_w;
    logic [3:0] mask_w;
    logic       compound_w;

    assign code_w     = allow_q ? {straps_q.fixed_hi, straps_q.fixed_lo} : 2'h0;
    assign mask_w     = fixed_mask(code_w);
    assign compound_w = |mask_w;

    assign captured_straps = straps_q;
    assign fixed_port_code = code_w;
    assign fixed_port_mask = mask_w;
    assign compound_device = compound_w;
    assign config_method   = {straps_q.select_b, straps_q.select_a};
    assign straps_valid    = (state_q == hsl_pkg::HSL_RUN);

    // control register
    logic [`HSL_CTRL_W-1:0] ctrl_q;
    logic [`HSL_CTRL_W-1:0] ctrl_d;
    logic                   hit_ctrl;
    logic                   hit_status;
    logic                   hit_any;
    logic                   wr_ctrl;

    assign hit_ctrl   = (paddr == `HSL_CTRL_OFFSET);
    assign hit_status = (paddr == `HSL_STATUS_OFFSET);
    assign hit_any    = hit_ctrl | hit_status;
    assign wr_ctrl    = psel & penable & pwrite & hit_ctrl & pstrb[0];
    assign ctrl_d     = wr_ctrl ? pwdata[`HSL_CTRL_W-1:0] : ctrl_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `HSL_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // indicator pins, driven only after the straps are caught
    logic speed_on;
    logic susp_on;
    logic speed_pin_d;
    logic susp_pin_d;
    logic speed_oe_d;
    logic susp_oe_d;
    logic speed_pin_q;
    logic susp_pin_q;
    logic speed_oe_q;
    logic susp_oe_q;

    assign speed_on    = hub_connected & hub_high_speed;
    assign susp_on     = hub_active;
    assign speed_pin_d = speed_on ^ straps_q.select_b;
    assign susp_pin_d  = susp_on ^ straps_q.fixed_lo;
    assign speed_oe_d  = straps_valid & ctrl_q[`HSL_CTRL_SPEED_LED_BIT];
    assign susp_oe_d   = straps_valid & ctrl_q[`HSL_CTRL_SUSP_LED_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_pin_q <= 1'b0;
            susp_pin_q  <= 1'b0;
            speed_oe_q  <= 1'b0;
            susp_oe_q   <= 1'b0;
        end else begin
            speed_pin_q <= speed_pin_d;
            susp_pin_q  <= susp_pin_d;
            speed_oe_q  <= speed_oe_d;
            susp_oe_q   <= susp_oe_d;
        end
    end

    assign upstream_speed_indicator_out = speed_pin_q;
    assign upstream_speed_indicator_oe  = speed_oe_q;
    assign suspend_indicator_out        = susp_pin_q;
    assign suspend_indicator_oe         = susp_oe_q;

    // status word and read path
    logic [31:0] status_w;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        setup;

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[`HSL_ST_VALID_BIT]                   = straps_valid;
        status_w[`HSL_ST_CODE_LSB +: 2]               = code_w;
        status_w[`HSL_ST_MASK_LSB +: 4]               = mask_w;
        status_w[`HSL_ST_COMPOUND_BIT]                = compound_w;
        status_w[`HSL_ST_METHOD_LSB +: 2]             = config_method;
        status_w[`HSL_ST_ALLOW_BIT]                   = allow_q;
        status_w[`HSL_ST_SPEED_BIT]                   = speed_on;
        status_w[`HSL_ST_SUSP_BIT]                    = susp_on;
    end

    assign setup   = psel & ~penable;
    assign rdata_d = ~setup        ? rdata_q :
                     hit_ctrl      ? {{(32-`HSL_CTRL_W){1'b0}}, ctrl_q} :
                     hit_status    ? status_w :
                                     32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

endmodule // hsl_top

`default_nettype wire

/* File: verif/hsl_board_model.sv */
`timescale 1ns/1ns
`default_nettype none

// strap resistors on the shared pins and the system reset driver
module hsl_board (
    // clock
    input  wire logic       pclk,
    // resistor levels {select_b, select_a, fixed_hi, fixed_lo}
    input  wire logic [3:0] strap,
    // device drive on shared pins
    input  wire logic       susp_out,
    input  wire logic       susp_oe,
    input  wire logic       speed_out,
    input  wire logic       speed_oe,
    // to the device
    output var  logic       presetn,
    output var  logic [3:0] pins
);
    initial presetn = 1'b0;
    // resistor sets the level unless the device drives the pin
    assign pins[0] = susp_oe ? susp_out : strap[0];
    assign pins[2:1] = strap[2:1];
    assign pins[3] = speed_oe ? speed_out : strap[3];
    // never shorter than 10 cycles, 1 us
    task pulse(input int n);
        presetn <= 1'b0;
        repeat (n < 10 ? 10 : n) @(posedge pclk);
        presetn <= 1'b1;
    endtask
endmodule // hsl_board

`default_nettype wire

/* File: verif/hsl_top_monitor.sv */
`timescale 1ns/1ns
`default_nettype none

module hsl_top_monitor (
    // clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // pins and hub status
    input wire logic                 fixed_port_strap_hi_in,
    input wire logic                 fixed_port_strap_lo_in,
    input wire logic                 config_method_select_a_in,
    input wire logic                 hub_connected,
    input wire logic                 hub_high_speed,
    input wire logic                 hub_active,
    // decoded outputs
    input wire hsl_pkg::hsl_straps_s captured_straps,
    input wire logic [1:0]           fixed_port_code,
    input wire logic [3:0]           fixed_port_mask,
    input wire logic                 compound_device,
    input wire logic [1:0]           config_method,
    input wire logic                 straps_valid,
    input wire logic                 suspend_indicator_out,
    input wire logic                 suspend_indicator_oe,
    input wire logic                 upstream_speed_indicator_out,
    input wire logic                 upstream_speed_indicator_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence cap_s;
        $rose(straps_valid);
    endsequence
    cap_fixed_a: assert property (cap_s |-> {captured_straps.fixed_hi, captured_straps.fixed_lo} ==
        $past({fixed_port_strap_hi_in, fixed_port_strap_lo_in}, 3)) else $error("fixed straps not caught");
    cap_select_a: assert property (cap_s |-> captured_straps.select_a == $past(config_method_select_a_in, 3))
        else $error("select a not caught");
    mask_decode_a: assert property (straps_valid |-> fixed_port_mask == (4'h7 >> (2'h3 - fixed_port_code)))
        else $error("bad fixed port mask");
    compound_flag_a: assert property (straps_valid |-> compound_device == (fixed_port_mask != 4'h0))
        else $error("bad compound flag");
    method_join_a: assert property (straps_valid |->
        config_method == {captured_straps.select_b, captured_straps.select_a}) else $error("bad method");
    speed_led_a: assert property (upstream_speed_indicator_oe |-> upstream_speed_indicator_out ==
        ($past(hub_connected & hub_high_speed) ^ captured_straps.select_b)) else $error("bad speed led");
    susp_led_a: assert property (suspend_indicator_oe |->
        suspend_indicator_out == ($past(hub_active) ^ captured_straps.fixed_lo)) else $error("bad suspend led");
    straps_hold_a: assert property ($past(straps_valid) |-> $stable(captured_straps))
        else $error("straps moved");
endmodule // hsl_top_monitor

bind hsl_top hsl_top_monitor mon (.*);

`default_nettype wire

/* File: verif/hsl_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hsl_consts.svh"

module hsl_top_tb_top;
    logic                   pclk = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [`HSL_ADDR_W-1:0] paddr = '0;
    logic [31:0]            pwdata = '0, prdata, rd;
    logic [3:0]             pstrb = 4'hF, strap = 4'h0, fixed_port_mask;
    logic                   strap_allow = 1'b0, hub_connected = 1'b0, hub_high_speed = 1'b0, hub_active = 1'b0;
    logic                   pready, pslverr, compound_device, straps_valid;
    logic                   suspend_indicator_out, suspend_indicator_oe;
    logic                   upstream_speed_indicator_out, upstream_speed_indicator_oe;
    logic [1:0]             fixed_port_code, config_method;
    hsl_pkg::hsl_straps_s   captured_straps;
    wire logic              presetn;
    wire logic [3:0]        pins;
    int                     error_cnt = 0, cmp_count = 0;
    // straps, allow, code, mask, compound, method
    logic [13:0]            rows [5] = '{{4'h0, 1'b1, 2'h0, 4'h0, 1'b0, 2'h0}, {4'h1, 1'b1, 2'h1, 4'h1, 1'b1, 2'h0},
                                         {4'h6, 1'b1, 2'h2, 4'h3, 1'b1, 2'h1}, {4'hB, 1'b1, 2'h3, 4'h7, 1'b1, 2'h2},
                                         {4'hF, 1'b0, 2'h0, 4'h0, 1'b0, 2'h3}};

    always #50 pclk = ~pclk;

    hsl_board board (.pclk(pclk), .strap(strap), .susp_out(suspend_indicator_out), .susp_oe(suspend_indicator_oe),
        .speed_out(upstream_speed_indicator_out), .speed_oe(upstream_speed_indicator_oe), .presetn(presetn),
        .pins(pins));
    hsl_top dut (.*, .fixed_port_strap_lo_in(pins[0]), .fixed_port_strap_hi_in(pins[1]),
        .config_method_select_a_in(pins[2]), .config_method_select_b_in(pins[3]));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) error_cnt++;
        @(posedge pclk);
    endtask

    task report_and_stop;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge pclk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        for (int i = 0; i < 5; i++) begin
            strap <= rows[i][13:10];
            strap_allow <= rows[i][9];
            board.pulse(20);
            repeat (3) @(posedge pclk);
            chk(captured_straps, rows[i][13:10]);
            chk(straps_valid, 1'b1);
            chk(fixed_port_code, rows[i][8:7]);
            chk(fixed_port_mask, rows[i][6:3]);
            chk(compound_device, rows[i][2]);
            chk(config_method, rows[i][1:0]);
            apb(1'b0, `HSL_STATUS_OFFSET, 32'h0);
            chk(rd[10:0], {rows[i][9], rows[i][1:0], rows[i][2], rows[i][6:3], rows[i][8:7], 1'b1});
        end
        strap <= 4'h0;
        hub_connected <= 1'b1;
        hub_high_speed <= 1'b1;
        hub_active <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(captured_straps, 4'hF);
        chk(upstream_speed_indicator_out, 1'b0);
        chk(suspend_indicator_out, 1'b0);
        hub_high_speed <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(upstream_speed_indicator_out, 1'b1);
        apb(1'b0, `HSL_CTRL_OFFSET, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 12'h008, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        chk(pready, 1'b1);
        apb(1'b1, `HSL_CTRL_OFFSET, 32'h0);
        apb(1'b0, `HSL_CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0);
        chk({upstream_speed_indicator_oe, suspend_indicator_oe}, 2'h0);
        // mid-run reset: outputs cleared while low, capture at first edge after release
        hub_high_speed <= 1'b1;
        strap <= 4'h4;
        strap_allow <= 1'b1;
        fork
            board.pulse(20);
            begin
                repeat (5) @(posedge pclk);
                chk(prdata, 32'h0);
                chk({straps_valid, suspend_indicator_oe, upstream_speed_indicator_oe, captured_straps}, 7'h00);
            end
        join
        @(posedge pclk);
        chk(straps_valid, 1'b0);
        @(posedge pclk);
        chk({straps_valid, captured_straps}, 5'h14);
        chk(config_method, 2'h1);
        @(posedge pclk);
        chk({upstream_speed_indicator_oe, suspend_indicator_oe}, 2'h3);
        chk({upstream_speed_indicator_out, suspend_indicator_out}, 2'h3);
        report_and_stop();
    end
endmodule // hsl_top_tb_top

`default_nettype wire
